// >>> src/pim_mapper.sv
// Process image mapper: layout at start-up, master and module word access
`timescale 1ns/1ns
module pim_mapper (
	input logic clk,
	input logic rst,
	input logic mod_valid,
	input pim_pkg::pim_mod_s mod,
	input logic enum_done,
	input logic mb_valid,
	input pim_pkg::pim_mb_req_s mb_req,
	output pim_pkg::pim_rsp_s mb_rsp,
	input logic io_valid,
	input pim_pkg::pim_io_req_s io_req,
	output pim_pkg::pim_rsp_s io_rsp,
	output logic image_ready,
	output logic image_overflow,
	output logic [8:0] in_words,
	output logic [8:0] out_words
);
	typedef enum logic [2:0] {S_COLLECT, S_CLEAR, S_BYTE, S_BIT, S_RUN} pim_state_e;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	function automatic logic [8:0] pim_words(input pim_pkg::pim_kind_e k, input logic [7:0] b);
		case (k)
			pim_pkg::PIM_ANALOG: pim_words = pim_pkg::ANA_WORDS;
			pim_pkg::PIM_CNT32: pim_words = pim_pkg::CNT32_WORDS;
			pim_pkg::PIM_CNT16X2: pim_words = pim_pkg::CNT16_WORDS;
			pim_pkg::PIM_PWM2: pim_words = pim_pkg::PWM_WORDS;
			default: pim_words = 9'({1'h0, b} + 9'h001) >> 1;
		endcase
	endfunction

	function automatic logic pim_is_cs(input pim_pkg::pim_kind_e k, input logic [7:0] off);
		pim_is_cs = ((k == pim_pkg::PIM_CNT32 || k == pim_pkg::PIM_CNT16X2 ||
			k == pim_pkg::PIM_PWM2) && off == pim_pkg::CS_OFF_A) ||
			(k == pim_pkg::PIM_PWM2 && off == pim_pkg::CS_OFF_B);
	endfunction

	pim_state_e st_reg;
	logic [8:0] cnt_reg;
	logic [6:0] count_reg;
	logic [13:0] in_ptr_reg;
	logic [13:0] out_ptr_reg;
	logic [8:0] byte_end_reg;
	pim_pkg::pim_slot_s slot_tab [pim_pkg::SLOTS];
	logic [15:0] in_img [pim_pkg::IMG_WORDS];
	logic [15:0] out_img [pim_pkg::IMG_WORDS];
	pim_pkg::pim_rsp_s mb_rsp_reg;
	pim_pkg::pim_rsp_s io_rsp_reg;
	logic ready_reg;
	logic ovf_reg;
	logic [8:0] in_words_reg;
	logic [8:0] out_words_reg;

	wire mod_keep = mod.in_width != 8'h00 || mod.out_width != 8'h00;
	wire store_mod = st_reg == S_COLLECT && mod_valid && mod_keep &&
		count_reg != 7'(pim_pkg::SLOTS);

	// Layout step, one slot per cycle
	wire pim_pkg::pim_slot_s cur = slot_tab[cnt_reg[5:0]];
	wire cur_dig = cur.mod.kind == pim_pkg::PIM_DIGITAL;
	wire pass_end = cnt_reg == {2'h0, count_reg};
	wire [13:0] cur_words = {1'h0, pim_words(cur.mod.kind, cur.mod.in_width), 4'h0};
	wire [13:0] cur_words_o = {1'h0, pim_words(cur.mod.kind, cur.mod.out_width), 4'h0};
	// byte pass places non-digital modules, bit pass the digital ones
	wire take = (st_reg == S_BYTE) ? !cur_dig : cur_dig;
	// digital need is the raw bit count, no per-module alignment
	wire [13:0] in_need = (!take || cur.mod.in_width == 8'h00) ? 14'h0000 :
		(cur_dig ? {6'h00, cur.mod.in_width} : cur_words);
	wire [13:0] out_need = (!take || cur.mod.out_width == 8'h00) ? 14'h0000 :
		(cur_dig ? {6'h00, cur.mod.out_width} : cur_words_o);
	// nothing is placed beyond word 255
	wire in_fit = 15'(in_ptr_reg) + 15'(in_need) <= 15'(pim_pkg::BIT_LIMIT);
	wire out_fit = 15'(out_ptr_reg) + 15'(out_need) <= 15'(pim_pkg::BIT_LIMIT);
	wire placing = (st_reg == S_BYTE || st_reg == S_BIT) && !pass_end;
	pim_pkg::pim_slot_s placed;
	always_comb begin
		placed = cur;
		if (take) begin
			// base is the running total of earlier placements
			placed.in_base = in_ptr_reg[12:0];
			placed.out_base = out_ptr_reg[12:0];
			if (!in_fit)
				placed.mod.in_width = 8'h00;
			if (!out_fit)
				placed.mod.out_width = 8'h00;
		end
	end

	// Module side access
	wire pim_pkg::pim_slot_s io_sl = slot_tab[io_req.slot];
	wire io_dig = io_sl.mod.kind == pim_pkg::PIM_DIGITAL;
	wire [7:0] io_width = io_req.we ? io_sl.mod.in_width : io_sl.mod.out_width;
	wire [12:0] io_base = io_req.we ? io_sl.in_base : io_sl.out_base;
	wire [8:0] io_lim = io_dig ? {1'h0, io_width} : pim_words(io_sl.mod.kind, io_width);
	wire io_bad = !ready_reg || {1'h0, io_req.slot} >= count_reg || io_width == 8'h00 ||
		{1'h0, io_req.off} >= io_lim;
	// byte modules land on word boundaries
	wire [12:0] io_bit = io_base + (io_dig ? {5'h00, io_req.off} : {1'h0, io_req.off, 4'h0});
	wire [7:0] io_word = io_bit[11:4];
	wire [3:0] io_sel = io_bit[3:0];
	wire io_cs = pim_is_cs(io_sl.mod.kind, io_req.off);
	wire [15:0] bit_mask = 16'h0001 << io_sel;
	wire [15:0] in_merge = (in_img[io_word] & ~bit_mask) | (io_req.wdata[0] ? bit_mask : 16'h0000);
	// counter and data bytes pass through in byte order
	wire [15:0] in_val = io_dig ? in_merge :
		(io_cs ? (io_req.wdata & pim_pkg::CS_MASK) : io_req.wdata);
	wire [15:0] out_word = out_img[io_word];
	// high byte of a control/status word reads as zero
	wire [15:0] out_val = io_dig ? {15'h0000, out_word[io_sel]} :
		(io_cs ? (out_word & pim_pkg::CS_MASK) : out_word);
	wire io_wr = io_valid && io_req.we && !io_bad;

	// Master side access
	wire mb_img = mb_req.addr[15:8] == pim_pkg::IMG_PAGE;
	// read-back window for the output image
	wire mb_rb = mb_req.addr[15:8] == pim_pkg::RB_PAGE && !mb_req.we;
	wire mb_bad = !ready_reg || !(mb_img || mb_rb);
	wire mb_wr = mb_valid && mb_req.we && !mb_bad;
	wire [15:0] mb_val = mb_rb ? out_img[mb_req.addr[7:0]] : in_img[mb_req.addr[7:0]];

	// Images are cleared once per start-up; writes only when the layout is fixed
	always_ff @(posedge clk) begin
		if (st_reg == S_CLEAR)
			in_img[cnt_reg[7:0]] <= 16'h0000;
		else if (io_wr)
			in_img[io_word] <= in_val;
	end

	always_ff @(posedge clk) begin
		if (st_reg == S_CLEAR)
			out_img[cnt_reg[7:0]] <= 16'h0000;
		else if (mb_wr)
			out_img[mb_req.addr[7:0]] <= mb_req.wdata;
	end

	always_ff @(posedge clk) begin
		if (store_mod)
			slot_tab[count_reg[5:0]] <= {mod, pim_pkg::BASE_START, pim_pkg::BASE_START};
		else if (placing)
			slot_tab[cnt_reg[5:0]] <= placed;
	end

	// layout only built between reset and entering run
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= S_COLLECT;
			cnt_reg <= 9'h000;
			count_reg <= 7'h00;
			in_ptr_reg <= 14'h0000;
			out_ptr_reg <= 14'h0000;
			byte_end_reg <= 9'h000;
			ovf_reg <= 1'b0;
		end else begin
			case (st_reg)
				S_COLLECT: begin
					if (store_mod)
						count_reg <= count_reg + 7'h01;
					if (enum_done)
						st_reg <= S_CLEAR;
				end
				S_CLEAR: begin
					cnt_reg <= (cnt_reg == pim_pkg::CLEAR_LAST) ? 9'h000 : cnt_reg + 9'h001;
					if (cnt_reg == pim_pkg::CLEAR_LAST)
						st_reg <= S_BYTE;
				end
				S_BYTE, S_BIT: begin
					if (pass_end) begin
						cnt_reg <= 9'h000;
						st_reg <= (st_reg == S_BYTE) ? S_BIT : S_RUN;
						byte_end_reg <= in_ptr_reg[12:4];
					end else begin
						cnt_reg <= cnt_reg + 9'h001;
						if (in_fit)
							in_ptr_reg <= in_ptr_reg + in_need;
						if (out_fit)
							out_ptr_reg <= out_ptr_reg + out_need;
						if (!in_fit || !out_fit)
							ovf_reg <= 1'b1;
					end
				end
				S_RUN: st_reg <= S_RUN;
				default: st_reg <= S_COLLECT;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ready_reg <= 1'b0;
			in_words_reg <= 9'h000;
			out_words_reg <= 9'h000;
		end else if (st_reg == S_BIT && pass_end) begin
			ready_reg <= 1'b1;
			in_words_reg <= 9'((in_ptr_reg + 14'h000F) >> 4);
			out_words_reg <= 9'((out_ptr_reg + 14'h000F) >> 4);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mb_rsp_reg <= '0;
			io_rsp_reg <= '0;
		end else begin
			mb_rsp_reg.ack <= mb_valid;
			mb_rsp_reg.err <= mb_valid && mb_bad;
			mb_rsp_reg.rdata <= (mb_valid && !mb_bad && !mb_req.we) ? mb_val : 16'h0000;
			io_rsp_reg.ack <= io_valid;
			io_rsp_reg.err <= io_valid && io_bad;
			io_rsp_reg.rdata <= (io_valid && !io_bad && !io_req.we) ? out_val : 16'h0000;
		end
	end

	assign mb_rsp = mb_rsp_reg;
	assign io_rsp = io_rsp_reg;
	assign image_ready = ready_reg;
	assign image_overflow = ovf_reg;
	assign in_words = in_words_reg;
	assign out_words = out_words_reg;

	property p_skip_empty;
		st_reg == S_COLLECT && mod_valid && !mod_keep |=> count_reg == $past(count_reg);
	endproperty
	a_skip_empty: assert property (p_skip_empty) else $error("empty module was stored");

	property p_readback;
		mb_valid && !mb_bad && mb_rb |=> mb_rsp.ack && !mb_rsp.err &&
			mb_rsp.rdata == out_img[$past(mb_req.addr[7:0])];
	endproperty
	a_readback: assert property (p_readback) else $error("read-back mismatch");

	property p_in_read;
		mb_valid && !mb_bad && mb_img && !mb_req.we && !io_wr |=>
			mb_rsp.rdata == in_img[$past(mb_req.addr[7:0])];
	endproperty
	a_in_read: assert property (p_in_read) else $error("input image read mismatch");

	property p_bits_last;
		st_reg == S_BIT |-> in_ptr_reg[12:4] >= byte_end_reg;
	endproperty
	a_bits_last: assert property (p_bits_last) else $error("bits placed before bytes");

	property p_bit_pack;
		placing && st_reg == S_BIT && cur_dig && in_fit |=>
			in_ptr_reg == $past(in_ptr_reg) + 14'($past(cur.mod.in_width));
	endproperty
	a_bit_pack: assert property (p_bit_pack) else $error("digital bits not packed");

	property p_analog_two;
		placing && st_reg == S_BYTE && cur.mod.kind == pim_pkg::PIM_ANALOG &&
			cur.mod.in_width != 8'h00 && in_fit |=> in_ptr_reg == $past(in_ptr_reg) + 14'h0020;
	endproperty
	a_analog_two: assert property (p_analog_two) else $error("analog not two words");

	property p_cnt_three;
		placing && st_reg == S_BYTE && cur.mod.kind == pim_pkg::PIM_CNT32 &&
			cur.mod.out_width != 8'h00 && out_fit |=> out_ptr_reg == $past(out_ptr_reg) + 14'h0030;
	endproperty
	a_cnt_three: assert property (p_cnt_three) else $error("counter not three words");

	property p_pwm_four;
		placing && st_reg == S_BYTE && cur.mod.kind == pim_pkg::PIM_PWM2 &&
			cur.mod.in_width != 8'h00 && in_fit |=> in_ptr_reg == $past(in_ptr_reg) + 14'h0040;
	endproperty
	a_pwm_four: assert property (p_pwm_four) else $error("pulse-width not four words");

	property p_cs_low;
		io_valid && !io_req.we && !io_bad && !io_dig && io_cs |=> io_rsp.rdata[15:8] == 8'h00;
	endproperty
	a_cs_low: assert property (p_cs_low) else $error("status high byte not zero");

	property p_start_zero;
		st_reg == S_CLEAR ##1 st_reg == S_BYTE |-> in_ptr_reg == 14'h0000 && out_ptr_reg == 14'h0000;
	endproperty
	a_start_zero: assert property (p_start_zero) else $error("layout not starting at 0");

	property p_frozen;
		st_reg == S_RUN |=> st_reg == S_RUN && ready_reg && $stable(in_ptr_reg);
	endproperty
	a_frozen: assert property (p_frozen) else $error("layout changed in run");
endmodule

// >>> src/pim_pkg.sv
// Shared constants and types for the process image mapper
package pim_pkg;
	localparam int IMG_WORDS = 256;
	localparam int SLOTS = 64;
	localparam logic [7:0] IMG_PAGE = 8'h00;
	localparam logic [15:0] RB_OFFSET = 16'h0200;
	localparam logic [7:0] RB_PAGE = RB_OFFSET[15:8];
	localparam logic [12:0] BASE_START = 13'h0000;
	localparam logic [13:0] BIT_LIMIT = 14'h1000;
	localparam logic [8:0] ANA_WORDS = 9'h002;
	localparam logic [8:0] CNT32_WORDS = 9'h003;
	localparam logic [8:0] CNT16_WORDS = 9'h003;
	localparam logic [8:0] PWM_WORDS = 9'h004;
	localparam logic [7:0] CS_OFF_A = 8'h00;
	localparam logic [7:0] CS_OFF_B = 8'h02;
	localparam logic [15:0] CS_MASK = 16'h00FF;
	localparam logic [8:0] CLEAR_LAST = 9'h0FF;

	typedef enum logic [2:0] {
		PIM_DIGITAL, PIM_ANALOG, PIM_BYTES, PIM_CNT32, PIM_CNT16X2, PIM_PWM2
	} pim_kind_e;

	// Width is a bit count for digital modules and a byte count otherwise
	typedef struct packed {
		pim_kind_e kind;
		logic [7:0] in_width;
		logic [7:0] out_width;
	} pim_mod_s;

	// Bases are bit addresses into the image; word = base[11:4]
	typedef struct packed {
		pim_mod_s mod;
		logic [12:0] in_base;
		logic [12:0] out_base;
	} pim_slot_s;

	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} pim_mb_req_s;

	typedef struct packed {
		logic we;
		logic [5:0] slot;
		logic [7:0] off;
		logic [15:0] wdata;
	} pim_io_req_s;

	typedef struct packed {
		logic ack;
		logic err;
		logic [15:0] rdata;
	} pim_rsp_s;
endpackage

// >>> tb/pim_master_model.sv
// Master-side model: one word request at a time, answer collected
`timescale 1ns/1ns
module pim_master_model (
	input logic clk,
	output logic mb_valid,
	output pim_pkg::pim_mb_req_s mb_req,
	input pim_pkg::pim_rsp_s mb_rsp
);
	initial begin
		mb_valid = 1'b0;
		mb_req = '0;
	end
	task automatic xfer(input logic we, input logic [15:0] addr, input logic [15:0] wd,
		output logic ok, output logic err, output logic [15:0] rd);
		@(negedge clk);
		mb_valid = 1'b1;
		mb_req = '{we: we, addr: addr, wdata: wd};
		// Answer stands for one cycle only, so take it before releasing
		@(negedge clk);
		ok = mb_rsp.ack;
		err = mb_rsp.err;
		rd = mb_rsp.rdata;
		mb_valid = 1'b0;
		// Released lines flip so a stale request never looks valid
		mb_req = ~mb_req;
	endtask
endmodule

// >>> tb/pim_mapper_bench.sv
// Self-checking bench for the process image mapper
`timescale 1ns/1ns
module pim_mapper_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mod_valid = 1'b0;
	pim_pkg::pim_mod_s mod = '0;
	logic enum_done = 1'b0;
	logic mb_valid;
	pim_pkg::pim_mb_req_s mb_req;
	pim_pkg::pim_rsp_s mb_rsp;
	logic io_valid = 1'b0;
	pim_pkg::pim_io_req_s io_req = '0;
	pim_pkg::pim_rsp_s io_rsp;
	logic image_ready;
	logic image_overflow;
	logic [8:0] in_words;
	logic [8:0] out_words;
	int bad_count = 0;
	int check_count = 0;
	logic timed_out = 1'b0;
	logic ok;
	logic err;
	logic [15:0] rd;
	always #2 clk = ~clk;
	pim_mapper pim_mapper_inst (.clk(clk), .rst(rst), .mod_valid(mod_valid), .mod(mod),
		.enum_done(enum_done), .mb_valid(mb_valid), .mb_req(mb_req), .mb_rsp(mb_rsp),
		.io_valid(io_valid), .io_req(io_req), .io_rsp(io_rsp), .image_ready(image_ready),
		.image_overflow(image_overflow), .in_words(in_words), .out_words(out_words));
	pim_master_model pim_master_model_inst (.clk(clk), .mb_valid(mb_valid),
		.mb_req(mb_req), .mb_rsp(mb_rsp));
	task automatic final_report;
		$display("checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic io(input logic we, input logic [5:0] s, input logic [7:0] o,
		input logic [15:0] wd);
		@(negedge clk);
		io_valid = 1'b1;
		io_req = '{we: we, slot: s, off: o, wdata: wd};
		@(negedge clk);
		ok = io_rsp.ack;
		err = io_rsp.err;
		rd = io_rsp.rdata;
		io_valid = 1'b0;
		io_req = ~io_req;
	endtask
	task automatic wait_ready;
		int n;
		n = 0;
		while (image_ready !== 1'b1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		if (image_ready !== 1'b1) begin
			bad_count++;
			timed_out = 1'b1;
			$display("unexpected image_ready: expected 1, seen %b", image_ready);
		end
	endtask
	// Checks ack, error flag and, when accepted, the returned word
	task automatic rsp(input string name, input logic e_err, input logic [15:0] e_rd);
		chk({name, " ack"}, 16'h0001, {15'h0000, ok});
		chk({name, " err"}, {15'h0000, e_err}, {15'h0000, err});
		if (!e_err) begin
			chk(name, e_rd, rd);
		end
	endtask
	task automatic mb(input logic we, input logic [15:0] a, input logic [15:0] wd);
		pim_master_model_inst.xfer(we, a, wd, ok, err, rd);
	endtask
	task automatic present(input pim_pkg::pim_kind_e k, input logic [7:0] i,
		input logic [7:0] o);
		@(negedge clk);
		mod_valid = 1'b1;
		mod = '{kind: k, in_width: i, out_width: o};
	endtask
	task automatic close_enum;
		@(negedge clk);
		mod_valid = 1'b0;
		enum_done = 1'b1;
		@(negedge clk);
		enum_done = 1'b0;
	endtask
	task automatic t_reset;
		chk("image_ready", 16'h0000, {15'h0000, image_ready});
		mb(1'b0, 16'h0000, 16'h0000);
		rsp("early read", 1'b1, 16'h0000);
	endtask
	// Stored slots: 0 analog, 1 digital, 2 counter, 3 pulse-width, 4 digital
	task automatic t_enum;
		present(pim_pkg::PIM_ANALOG, 8'h04, 8'h04);
		present(pim_pkg::PIM_DIGITAL, 8'h00, 8'h00);
		present(pim_pkg::PIM_DIGITAL, 8'h03, 8'h02);
		present(pim_pkg::PIM_CNT32, 8'h05, 8'h05);
		present(pim_pkg::PIM_PWM2, 8'h06, 8'h06);
		present(pim_pkg::PIM_DIGITAL, 8'h0E, 8'h00);
		close_enum();
		wait_ready();
		chk("in_words", 16'h000B, {7'h00, in_words});
		chk("out_words", 16'h000A, {7'h00, out_words});
		chk("overflow", 16'h0000, {15'h0000, image_overflow});
	endtask
	task automatic t_input;
		io(1'b1, 6'h00, 8'h01, 16'h1357);
		io(1'b1, 6'h02, 8'h01, 16'hBEEF);
		io(1'b1, 6'h02, 8'h00, 16'h12A5);
		io(1'b1, 6'h03, 8'h02, 16'hFF5A);
		io(1'b1, 6'h03, 8'h03, 16'h2468);
		io(1'b1, 6'h01, 8'h00, 16'h0001);
		io(1'b1, 6'h04, 8'h0C, 16'h0001);
		io(1'b1, 6'h04, 8'h0D, 16'h0001);
		mb(1'b0, 16'h0001, 16'h0000);
		rsp("analog word", 1'b0, 16'h1357);
		mb(1'b0, 16'h0003, 16'h0000);
		rsp("counter data", 1'b0, 16'hBEEF);
		mb(1'b0, 16'h0002, 16'h0000);
		rsp("counter status", 1'b0, 16'h00A5);
		mb(1'b0, 16'h0007, 16'h0000);
		rsp("pwm status", 1'b0, 16'h005A);
		mb(1'b0, 16'h0008, 16'h0000);
		rsp("pwm data", 1'b0, 16'h2468);
		mb(1'b0, 16'h0009, 16'h0000);
		rsp("digital word", 1'b0, 16'h8001);
		mb(1'b0, 16'h000A, 16'h0000);
		rsp("digital carry", 1'b0, 16'h0001);
	endtask
	task automatic t_output;
		mb(1'b1, 16'h0003, 16'h1234);
		rsp("write", 1'b0, 16'h0000);
		mb(1'b0, 16'h0203, 16'h0000);
		rsp("read-back", 1'b0, 16'h1234);
		mb(1'b0, 16'h0003, 16'h0000);
		rsp("input kept", 1'b0, 16'hBEEF);
		io(1'b0, 6'h02, 8'h01, 16'h0000);
		rsp("preset", 1'b0, 16'h1234);
		mb(1'b1, 16'h0002, 16'hABCD);
		io(1'b0, 6'h02, 8'h00, 16'h0000);
		rsp("control", 1'b0, 16'h00CD);
		mb(1'b1, 16'h0009, 16'h0002);
		io(1'b0, 6'h01, 8'h01, 16'h0000);
		rsp("out bit", 1'b0, 16'h0001);
		mb(1'b1, 16'h0205, 16'h0000);
		rsp("read-back write", 1'b1, 16'h0000);
		mb(1'b0, 16'h0100, 16'h0000);
		rsp("past image", 1'b1, 16'h0000);
		mb(1'b0, 16'h00FF, 16'h0000);
		rsp("last word", 1'b0, 16'h0000);
	endtask
	task automatic t_refuse;
		io(1'b1, 6'h05, 8'h00, 16'h0000);
		rsp("bad slot", 1'b1, 16'h0000);
		io(1'b1, 6'h00, 8'h02, 16'h0000);
		rsp("bad offset", 1'b1, 16'h0000);
		io(1'b0, 6'h04, 8'h00, 16'h0000);
		rsp("empty side", 1'b1, 16'h0000);
	endtask
	// A late module must not disturb a fixed layout
	task automatic t_fixed;
		present(pim_pkg::PIM_ANALOG, 8'h04, 8'h04);
		close_enum();
		repeat (300) @(negedge clk);
		chk("in_words kept", 16'h000B, {7'h00, in_words});
		mb(1'b0, 16'h0002, 16'h0000);
		rsp("layout kept", 1'b0, 16'h00A5);
	endtask
	// Restart: dual counter, generic bytes and an output-only digital module
	task automatic t_restart;
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		chk("ready after reset", 16'h0000, {15'h0000, image_ready});
		present(pim_pkg::PIM_CNT16X2, 8'h05, 8'h05);
		present(pim_pkg::PIM_DIGITAL, 8'h00, 8'h09);
		present(pim_pkg::PIM_BYTES, 8'h03, 8'h00);
		close_enum();
		wait_ready();
		if (!timed_out) begin
			chk("new in_words", 16'h0005, {7'h00, in_words});
			chk("new out_words", 16'h0004, {7'h00, out_words});
			io(1'b1, 6'h00, 8'h02, 16'h5678);
			mb(1'b0, 16'h0002, 16'h0000);
			rsp("counter 2 reading", 1'b0, 16'h5678);
			io(1'b1, 6'h00, 8'h00, 16'h33C1);
			mb(1'b0, 16'h0000, 16'h0000);
			rsp("dual status", 1'b0, 16'h00C1);
			io(1'b1, 6'h02, 8'h01, 16'h0A0B);
			mb(1'b0, 16'h0004, 16'h0000);
			rsp("byte module", 1'b0, 16'h0A0B);
			mb(1'b1, 16'h0001, 16'h1111);
			io(1'b0, 6'h00, 8'h01, 16'h0000);
			rsp("counter 1 load", 1'b0, 16'h1111);
			mb(1'b1, 16'h0003, 16'h0100);
			io(1'b0, 6'h01, 8'h08, 16'h0000);
			rsp("ninth out bit", 1'b0, 16'h0001);
			io(1'b1, 6'h01, 8'h00, 16'h0001);
			rsp("no input side", 1'b1, 16'h0000);
		end
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_enum();
		if (!timed_out) begin
			t_input();
			t_output();
			t_refuse();
			t_fixed();
			t_restart();
		end
		final_report();
	end
endmodule
